// ===== core/ntw_accum.sv
// Phase accumulators for the three oscillators
`timescale 1ns/1ps
`default_nettype none
module ntw_accum (
    input wire logic pclk,
    input wire logic presetn,
    ntw_acc_if.acc acc
);
    // ==========================================
    // Active words and accumulators
    logic [63:0] active [3];
    logic [63:0] next_active [3];
    logic [63:0] phase [3];
    logic [63:0] next_phase [3];

    always_comb begin
        for (int i = 0; i < ntw_pkg::NUM_NCO; i++) begin
            next_active[i] = acc.load ? acc.word[i] : active[i];
            if (acc.resync) begin
                next_phase[i] = '0;
            end else if (acc.run) begin
                // Plain add wraps modulo 2^64; signed words give mirrored tones
                next_phase[i] = phase[i] + active[i];
            end else begin
                next_phase[i] = phase[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ntw_pkg::NUM_NCO; i++) begin
                active[i] <= ntw_pkg::WORD_RESET;
                phase[i] <= '0;
            end
        end else begin
            active <= next_active;
            phase <= next_phase;
        end
    end

    assign acc.phase = phase;
endmodule
`default_nettype wire

// ===== core/ntw_bank.sv
// APB register bank for oscillator tuning words with sync-gated update
`timescale 1ns/1ps
`default_nettype none
module ntw_bank #(
    parameter int SYNC_PERIOD = ntw_pkg::SELF_SYNC_PERIOD
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_pin,
    output logic sync_event,
    output logic [63:0] nco1_phase
);
    // Counter is at most 16 bits; a period below 2 would tick every cycle
    if (SYNC_PERIOD < 2 || SYNC_PERIOD > 65536) begin : g_bad_period
        $error("SYNC_PERIOD out of range");
    end

    localparam int CW = $clog2(SYNC_PERIOD);

    ntw_acc_if acc_bus ();

    ntw_accum u_accum (
        .pclk(pclk),
        .presetn(presetn),
        .acc(acc_bus)
    );

    // ==========================================
    // Pin synchroniser and edge detect
    logic pin_meta, pin_sync, pin_prev;
    logic next_pin_prev;
    always_comb begin
        next_pin_prev = pin_sync;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= sync_pin;
            pin_sync <= pin_meta;
            pin_prev <= next_pin_prev;
        end
    end

    // ==========================================
    // Registers
    logic [63:0] word [3];
    logic [63:0] next_word [3];
    logic [31:0] ctrl, next_ctrl;
    logic [1:0] phase_sel, next_phase_sel;
    logic [CW-1:0] ss_cnt, next_ss_cnt;
    logic pend, next_pend;
    logic load, next_load;
    logic run, next_run;
    logic resync, next_resync;
    logic sync_q, next_sync_q;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic wr, rd, sw_fire, ss_tick, ev, fast_reconfig_enable;

    function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Index of tuning word for an address, 3 when not a word address
    function automatic logic [1:0] word_idx(input logic [11:0] a);
        // Only bit 2 is dropped, so unaligned addresses stay unmapped
        unique case (a & 12'hffb)
            ntw_pkg::ADDR_NCO1_LO: word_idx = 2'h0;
            ntw_pkg::ADDR_NCO2_LO: word_idx = 2'h1;
            ntw_pkg::ADDR_NCO3_LO: word_idx = 2'h2;
            default: word_idx = 2'h3;
        endcase
    endfunction

    always_comb begin
        logic [1:0] wi;
        logic [1:0] src;
        wi = word_idx(paddr);
        fast_reconfig_enable = ctrl[ntw_pkg::CTRL_FAST_RECONFIG_ENABLE_BIT];
        src = ctrl[ntw_pkg::CTRL_SRC_LSB +: ntw_pkg::CTRL_SRC_W];
        // Access is decoded in its first cycle: pready pulses in the second, one wait state
        wr = psel && penable && pwrite && !pready;
        rd = psel && penable && !pwrite && !pready;
        next_word = word;
        next_ctrl = ctrl;
        next_phase_sel = phase_sel;
        next_prdata = 32'h0;
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        sw_fire = 1'b0;
        if (wr) begin
            if (wi != 2'h3) begin
                if (paddr[2]) begin
                    next_word[wi][63:32] = byte_merge(word[wi][63:32], pwdata, pstrb);
                end else begin
                    next_word[wi][31:0] = byte_merge(word[wi][31:0], pwdata, pstrb);
                end
            end else if (paddr == ntw_pkg::ADDR_CTRL) begin
                next_ctrl = byte_merge(ctrl, pwdata, pstrb) & ntw_pkg::CTRL_MASK;
                // Fires only on a 0 to 1 write of the trigger bit
                sw_fire = next_ctrl[ntw_pkg::CTRL_SW_SYNC_BIT] &&
                          !ctrl[ntw_pkg::CTRL_SW_SYNC_BIT] && !fast_reconfig_enable;
            end else if (paddr == ntw_pkg::ADDR_PHASE_SEL) begin
                next_phase_sel = pstrb[0] ? pwdata[1:0] : phase_sel;
            end else if (paddr != ntw_pkg::ADDR_STATUS) begin
                next_pslverr = 1'b1;
            end
        end
        if (rd) begin
            if (wi != 2'h3) begin
                next_prdata = paddr[2] ? word[wi][63:32] : word[wi][31:0];
            end else if (paddr == ntw_pkg::ADDR_CTRL) begin
                next_prdata = ctrl;
            end else if (paddr == ntw_pkg::ADDR_STATUS) begin
                next_prdata = {31'h0, pend};
            end else if (paddr == ntw_pkg::ADDR_PHASE_SEL) begin
                next_prdata = {30'h0, phase_sel};
            end else if (paddr == ntw_pkg::ADDR_PHASE_LO && phase_sel != 2'h3) begin
                next_prdata = acc_bus.phase[phase_sel][31:0];
            end else if (paddr == ntw_pkg::ADDR_PHASE_HI && phase_sel != 2'h3) begin
                next_prdata = acc_bus.phase[phase_sel][63:32];
            end else begin
                next_pslverr = 1'b1;
            end
        end

        // Self-sync counter runs only with the datapath enabled
        ss_tick = 1'b0;
        next_ss_cnt = ss_cnt;
        if (ctrl[ntw_pkg::CTRL_SELF_SYNC_BIT] && ctrl[ntw_pkg::CTRL_DATAPATH_ENABLE_BIT]) begin
            ss_tick = (ss_cnt == CW'(SYNC_PERIOD - 1));
            next_ss_cnt = ss_tick ? '0 : ss_cnt + 1'b1;
        end else begin
            next_ss_cnt = '0;
        end

        ev = ss_tick;
        unique case (src)
            ntw_pkg::SRC_SW: ev = ev || sw_fire;
            ntw_pkg::SRC_PIN: ev = ev || (pin_sync && !pin_prev);
            ntw_pkg::SRC_BOTH: ev = ev || sw_fire || (pin_sync && !pin_prev);
            ntw_pkg::SRC_NONE: ev = ev;
        endcase
        if (fast_reconfig_enable) begin
            ev = 1'b0;
        end

        // A write in the event cycle stays pending: set wins
        next_pend = (wr && wi != 2'h3) || (pend && !ev);
        next_load = ev;
        next_resync = ss_tick && !fast_reconfig_enable;
        next_run = ctrl[ntw_pkg::CTRL_DATAPATH_ENABLE_BIT] && !fast_reconfig_enable;
        next_sync_q = ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ntw_pkg::NUM_NCO; i++) begin
                word[i] <= ntw_pkg::WORD_RESET;
            end
            ctrl <= ntw_pkg::CTRL_RESET;
            phase_sel <= 2'h0;
            ss_cnt <= '0;
            pend <= 1'b0;
            load <= 1'b0;
            run <= 1'b0;
            resync <= 1'b0;
            sync_q <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            word <= next_word;
            ctrl <= next_ctrl;
            phase_sel <= next_phase_sel;
            ss_cnt <= next_ss_cnt;
            pend <= next_pend;
            load <= next_load;
            run <= next_run;
            resync <= next_resync;
            sync_q <= next_sync_q;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================
    // Accumulator bank hookup
    assign acc_bus.word = word;
    assign acc_bus.load = load;
    assign acc_bus.run = run;
    assign acc_bus.resync = resync;

    logic [63:0] nco1_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco1_q <= '0;
        end else begin
            nco1_q <= acc_bus.phase[0];
        end
    end
    assign nco1_phase = nco1_q;
    assign sync_event = sync_q;
endmodule
`default_nettype wire

// ===== shared/ntw_acc_if.sv
// Interface carrying tuning words and update strobes to the accumulator bank
`timescale 1ns/1ps
`default_nettype none
interface ntw_acc_if;
    logic [63:0] word [3];
    logic load;
    logic run;
    logic resync;
    logic [63:0] phase [3];
    modport bank (output word, output load, output run, output resync, input phase);
    modport acc (input word, input load, input run, input resync, output phase);
endinterface
`default_nettype wire

// ===== shared/ntw_pkg.sv
// Package of register map, field layout and timing constants for the tuning word bank
`default_nettype none
package ntw_pkg;
    // ==========================================
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_NCO1_LO = 12'h328;
    localparam logic [11:0] ADDR_NCO1_HI = 12'h32c;
    localparam logic [11:0] ADDR_NCO2_LO = 12'h330;
    localparam logic [11:0] ADDR_NCO2_HI = 12'h334;
    localparam logic [11:0] ADDR_NCO3_LO = 12'h338;
    localparam logic [11:0] ADDR_NCO3_HI = 12'h33c;
    localparam logic [11:0] ADDR_CTRL = 12'h300;
    localparam logic [11:0] ADDR_STATUS = 12'h304;
    localparam logic [11:0] ADDR_PHASE_SEL = 12'h308;
    localparam logic [11:0] ADDR_PHASE_LO = 12'h30c;
    localparam logic [11:0] ADDR_PHASE_HI = 12'h310;
    // ==========================================
    // Control register fields
    localparam int CTRL_SW_SYNC_BIT = 0;
    localparam int CTRL_SELF_SYNC_BIT = 1;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_SRC_W = 2;
    localparam int CTRL_DATAPATH_ENABLE_BIT = 4;
    localparam int CTRL_FAST_RECONFIG_ENABLE_BIT = 5;
    localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
    // Sync sources
    localparam logic [1:0] SRC_SW = 2'h0;
    localparam logic [1:0] SRC_PIN = 2'h1;
    localparam logic [1:0] SRC_BOTH = 2'h2;
    localparam logic [1:0] SRC_NONE = 2'h3;
    // ==========================================
    // Reset values and timing
    localparam logic [63:0] WORD_RESET = 64'h0;
    localparam logic [31:0] CTRL_RESET = 32'h0;
    localparam int SELF_SYNC_PERIOD = 256;
    localparam int NUM_NCO = 3;
    localparam int WORD_W = 64;
endpackage
`default_nettype wire

// ===== sim/ntw_bank_props.sv
// Port checker for the tuning word bank
`timescale 1ns/1ps
`default_nettype none
module ntw_bank_props #(
    parameter int SYNC_PERIOD = ntw_pkg::SELF_SYNC_PERIOD
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sync_pin,
    input wire logic sync_event,
    input wire logic [63:0] nco1_phase
);
    // ==========================================
    // Shadow of the control register, built from completed writes
    logic [5:0] ctl;
    logic [15:0] gap;
    logic wr_ctl;
    logic ss_on;
    assign wr_ctl = pready && pwrite && paddr == ntw_pkg::ADDR_CTRL;
    assign ss_on = ctl[1] && ctl[4] && !ctl[5];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 6'h00;
            gap <= 16'h0000;
        end else begin
            ctl <= wr_ctl ? pwdata[5:0] : ctl;
            gap <= (sync_event || !ss_on) ? 16'h0000 : gap + 16'h0001;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_after: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_unmapped_err: assert property (psel && penable && !pready && !(paddr inside
        {12'h300, 12'h304, 12'h308, 12'h30c, 12'h310, 12'h328, 12'h32c, 12'h330,
        12'h334, 12'h338, 12'h33c}) |=> pslverr)
        else $error("unmapped access not refused");
    chk_event_pulse: assert property (sync_event |=> !sync_event)
        else $error("sync pulse too long");
    chk_fr_quiet: assert property (ctl[5] && $past(ctl[5]) && $past(ctl[5], 2) |-> !sync_event)
        else $error("sync during fast reconfiguration");
    // Source and fast reconfiguration are those in force before the trigger write
    chk_sw_fire: assert property (wr_ctl && pwdata[0] && !ctl[0] && !ctl[5]
        && (ctl[3:2] == ntw_pkg::SRC_SW || ctl[3:2] == ntw_pkg::SRC_BOTH)
        |-> ##[0:3] sync_event)
        else $error("software trigger did not fire");
    // Small slack: the design's own tick may lag the shadow by the event pipeline
    chk_self_period: assert property (gap <= SYNC_PERIOD + 2)
        else $error("self sync period exceeded");
    cover property (sync_event);
    cover property (pslverr);
    cover property (wr_ctl && pwdata[0]);
endmodule
bind ntw_bank ntw_bank_props #(.SYNC_PERIOD(SYNC_PERIOD)) u_ntw_bank_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_pin(sync_pin), .sync_event(sync_event), .nco1_phase(nco1_phase));
`default_nettype wire

// ===== sim/ntw_bank_tb.sv
// Self-checking bench for the tuning word bank
`timescale 1ns/1ps
`default_nettype none
module ntw_bank_tb;
    localparam int PER = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sync_pin = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sync_event;
    logic [63:0] nco1_phase;
    logic [31:0] rd;
    logic err;
    logic [63:0] d;
    logic [31:0] wv [6] = '{32'hffff_fff0, 32'hffff_ffff, 32'h0000_0100, 32'h8000_0000,
        32'h1234_5678, 32'h0000_0001};
    int miscompares = 0;
    int checked = 0;
    ntw_bank #(.SYNC_PERIOD(PER)) u_ntw_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
        .sync_event(sync_event), .nco1_phase(nco1_phase));
    always #50 pclk = ~pclk;
    // ==========================================
    // Tasks
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits for pready as long as it takes; the watchdog catches a hung slave
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        check(n, 2);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Phase step over one clock, sampled at two consecutive edges
    task step();
        logic [63:0] p0;
        repeat (3) @(posedge pclk);
        p0 = nco1_phase;
        @(posedge pclk);
        d = nco1_phase - p0;
    endtask
    task finish_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        int n;
        logic [63:0] ph;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'h328 + 12'(4 * i), 32'h0);
            check(rd, 32'h0);
            apb(1'b1, 12'h328 + 12'(4 * i), wv[i]);
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'h328 + 12'(4 * i), 32'h0);
            check(rd, wv[i]);
        end
        apb(1'b0, ntw_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h10);
        step();
        check(d, 64'h0);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h11);
        step();
        check(d, 64'hffff_ffff_ffff_fff0);
        apb(1'b0, ntw_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        // Trigger already high: a second one must not apply the new word
        apb(1'b1, ntw_pkg::ADDR_NCO1_LO, 32'h10);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h11);
        step();
        check(d, 64'hffff_ffff_ffff_fff0);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h30);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h31);
        step();
        check(d, 64'h0);
        apb(1'b0, ntw_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h14);
        sync_pin <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sync_event !== 1'b1 && n < 20);
        check(n < 20, 1'b1);
        sync_pin <= 1'b0;
        step();
        check(d, 64'hffff_ffff_0000_0010);
        apb(1'b1, ntw_pkg::ADDR_NCO2_LO, 32'h200);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h1e);
        repeat (2 * PER + 4) @(posedge pclk);
        apb(1'b0, ntw_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h320, 32'h0);
        check({err, rd}, 33'h1_0000_0000);
        // Software trigger with both sources selected, then oscillator 3 seen through the phase readback
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h08);
        apb(1'b1, ntw_pkg::ADDR_NCO3_LO, 32'h5);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h09);
        apb(1'b0, ntw_pkg::ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, ntw_pkg::ADDR_PHASE_SEL, 32'h2);
        apb(1'b0, ntw_pkg::ADDR_PHASE_LO, 32'h0);
        ph[31:0] = rd;
        apb(1'b0, ntw_pkg::ADDR_PHASE_HI, 32'h0);
        ph[63:32] = rd;
        // Enable and disable pass the same pipeline, so exactly four steps land
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h18);
        apb(1'b1, ntw_pkg::ADDR_CTRL, 32'h08);
        apb(1'b0, ntw_pkg::ADDR_PHASE_LO, 32'h0);
        d[31:0] = rd;
        apb(1'b0, ntw_pkg::ADDR_PHASE_HI, 32'h0);
        d[63:32] = rd;
        check(d - ph, 64'h0000_0004_0000_0014);
        apb(1'b1, ntw_pkg::ADDR_PHASE_SEL, 32'h3);
        apb(1'b0, ntw_pkg::ADDR_PHASE_LO, 32'h0);
        check({err, rd}, 33'h1_0000_0000);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
